// ===== core/acqb_regs.vh
`ifndef ACQB_REGS_VH
`define ACQB_REGS_VH
// Host I/O register offsets within the switch-selected block (word index, 3 bits).
`define ACQB_IO_CTRL 3'h0
`define ACQB_IO_BASE 3'h1
`define ACQB_IO_LEVELS 3'h2
`define ACQB_IO_STATUS 3'h3
`define ACQB_IO_DATA 3'h4
// Processor-side timer registers.
`define ACQB_T_CONV 3'h0
`define ACQB_T_SCAN 3'h1
`define ACQB_T_COUNT 3'h2
`define ACQB_T_CFG 3'h3
`define ACQB_T_STATUS 3'h4
// Control register fields.
`define ACQB_CTRL_WEN 0
`define ACQB_CTRL_PRST 1
`define ACQB_CTRL_RESET 8'h02
// Configuration register fields.
`define ACQB_CFG_RUN 0
`define ACQB_CFG_EXTTB 1
`define ACQB_CFG_SSH 2
`define ACQB_CFG_REPEAT 3
// Memory window: 512 KB is 2^19 bytes, in a 24-bit (16 MB) space.
`define ACQB_WIN_BITS 19
`define ACQB_MEM_AW 17
// Minimum conversion interval: 250 ns (4 MHz) at 10 ns per cycle.
`define ACQB_CONV_MIN_NS 250
`define ACQB_CLK_NS 10
`define ACQB_CONV_MIN_CYC ((`ACQB_CONV_MIN_NS + `ACQB_CLK_NS - 1) / `ACQB_CLK_NS)
`define ACQB_FIFO_DEPTH 16
`endif

// ===== core/acqb_ctrl.v
// Summary of operation
// - Timer paces conversions and scans separately.
// - Sample counter ends or repeats array sampling.
// - Timebase selects crystal or external clock.
// - Every conversion result goes into FIFO unless it is full.
// - FIFO and DMA raise processor interrupts.
// - Shared memory is 128K by 32 bits.
// - Host reaches 32-bit words as halves.
// - Arbiter grants host or processor, holds other.
// - I/O block at switch base; host sets window.
// - Window disabled after reset until enabled.
// - 512 KB window anywhere in 16 MB.
// - Control bit holds processor reset until cleared.
// - Host may reset and relocate any time.
// - Host interrupt on buffer ready, DMA request.
// - Host DMA and interrupt levels software set.
// - Sample-hold option: sample four, convert sequentially.
// - Up to 4 MHz, 12 or 14 bit results.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`include "acqb_regs.vh"
`default_nettype none
module acqb_ctrl #(
  parameter ADC_BITS = 14
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [7:0] io_sw_i,
  input wire [15:0] io_addr_i,
  input wire [15:0] io_wdata_i,
  input wire io_wr_i,
  input wire io_rd_i,
  output reg [15:0] io_rdata_o,
  input wire [23:0] mem_addr_i,
  input wire [15:0] mem_wdata_i,
  input wire mem_wr_i,
  input wire mem_rd_i,
  output reg [15:0] mem_rdata_o,
  output reg mem_hit_o,
  output reg mem_wait_o,
  input wire [2:0] p_addr_i,
  input wire [31:0] p_wdata_i,
  input wire p_wr_i,
  input wire p_rd_i,
  output reg [31:0] p_rdata_o,
  input wire [16:0] pm_addr_i,
  input wire [31:0] pm_wdata_i,
  input wire pm_wr_i,
  input wire pm_rd_i,
  output reg [31:0] pm_rdata_o,
  output reg pm_wait_o,
  input wire p_dma_done_i,
  input wire p_buf_ready_i,
  input wire p_dma_req_i,
  output reg p_irq_fifo_o,
  output reg p_irq_dma_o,
  output reg p_reset_o,
  input wire ext_tb_i,
  output reg adc_start_o,
  output reg sh_hold_o,
  output reg [1:0] adc_chan_o,
  input wire adc_valid_i,
  input wire [ADC_BITS-1:0] adc_data_i,
  input wire [1:0] adc_tag_i,
  output reg fifo_valid_o,
  output reg [15:0] fifo_data_o,
  input wire fifo_ready_i,
  output reg [7:0] host_irq_o,
  output reg [7:0] host_drq_o
);
  // Shared memory, 128K words of 32 bits.
  reg [31:0] mem [0:(1<<`ACQB_MEM_AW)-1];
  // Host I/O registers.
  reg [7:0] ctrl_q;
  reg [7:0] base_q;
  reg [5:0] levels_q;
  reg [15:0] lo_hold_q;
  // Processor timer registers.
  reg [15:0] conv_iv_q;
  reg [15:0] scan_iv_q;
  reg [15:0] count_q;
  reg [3:0] cfg_q;
  reg [15:0] conv_cnt_q;
  reg [15:0] scan_cnt_q;
  reg [15:0] done_q;
  reg [1:0] chan_q;
  reg in_scan_q;
  reg ovf_q;
  // Timebase synchroniser, three stages.
  reg [2:0] tb_sync_q;
  reg tb_level_q;
  // FIFO storage.
  reg [15:0] fifo [0:`ACQB_FIFO_DEPTH-1];
  reg [4:0] wr_ptr_q;
  reg [4:0] rd_ptr_q;
  // Two-entry output skid buffer.
  reg [15:0] ob_data_q [0:1];
  reg [1:0] ob_cnt_q;
  reg ob_rd_q;

  // Is the I/O address inside the switch-selected block.
  function io_hit;
    input [15:0] a;
    input [7:0] sw;
    begin
      io_hit = (a[15:8] == sw) && (a[7:3] == 5'h00);
    end
  endfunction

  wire io_sel = io_hit(io_addr_i, io_sw_i);
  wire [2:0] io_reg = io_addr_i[2:0];
  wire win_en = ctrl_q[`ACQB_CTRL_WEN];
  // Window decode: 512 KB block on base, 16 MB space.
  wire mem_sel = win_en && (mem_addr_i[23:`ACQB_WIN_BITS] == base_q[4:0]);
  wire host_req = mem_sel && (mem_wr_i || mem_rd_i);
  wire proc_req = pm_wr_i || pm_rd_i;
  wire [16:0] h_word = mem_addr_i[18:2];
  wire h_high = mem_addr_i[1];
  // Timebase tick: internal crystal every cycle or external edge.
  wire tb_ext_lvl = (tb_sync_q[2] == tb_sync_q[1]) ? tb_sync_q[1] : tb_level_q;
  wire tb_tick = cfg_q[`ACQB_CFG_EXTTB] ? (tb_ext_lvl && !tb_level_q) : 1'b1;
  wire [4:0] fifo_lvl = wr_ptr_q - rd_ptr_q;
  wire fifo_full = (fifo_lvl == `ACQB_FIFO_DEPTH);
  wire fifo_empty = (fifo_lvl == 5'h00);
  wire ob_push = !fifo_empty && (ob_cnt_q < 2'd2);
  // Shortest legal conversion spacing in cycles, held at the counter's width.
  localparam [15:0] CONV_MIN = `ACQB_CONV_MIN_CYC;
  wire [15:0] conv_lim = (conv_iv_q < CONV_MIN) ? CONV_MIN : conv_iv_q;
  // Converter result widened to 14 bits, so a 12-bit variant gets zero high bits.
  reg [13:0] adc_ext;
  always @* begin
    adc_ext = 14'h0000;
    adc_ext[ADC_BITS-1:0] = adc_data_i;
  end
  // Priority toggle: the last loser wins the next tie.
  reg host_pri_q;
  wire host_gnt = host_req && (!proc_req || host_pri_q);
  wire proc_gnt = proc_req && !host_gnt;

  // Host I/O register writes; reset leaves window off and processor held.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_q <= `ACQB_CTRL_RESET;
      base_q <= 8'h00;
      levels_q <= 6'h00;
    end else if (io_wr_i && io_sel) begin
      case (io_reg)
        `ACQB_IO_CTRL: ctrl_q <= io_wdata_i[7:0];
        `ACQB_IO_BASE: base_q <= io_wdata_i[7:0];
        `ACQB_IO_LEVELS: levels_q <= io_wdata_i[5:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Host I/O read data, one cycle after the strobe.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      io_rdata_o <= 16'h0000;
    end else if (io_rd_i && io_sel) begin
      case (io_reg)
        `ACQB_IO_CTRL: io_rdata_o <= {8'h00, ctrl_q};
        `ACQB_IO_BASE: io_rdata_o <= {8'h00, base_q};
        `ACQB_IO_LEVELS: io_rdata_o <= {10'h000, levels_q};
        `ACQB_IO_STATUS: io_rdata_o <= {11'h000, ovf_q, fifo_full, in_scan_q, pm_wait_o, mem_wait_o};
        default: io_rdata_o <= 16'h0000;
      endcase
    end else begin
      io_rdata_o <= 16'h0000;
    end
  end

  // Processor reset line follows the control bit.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      p_reset_o <= 1'b1;
    end else begin
      p_reset_o <= ctrl_q[`ACQB_CTRL_PRST];
    end
  end

  // Shared memory arbitration and access; a low-then-high half-word write pair assembles a word.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      host_pri_q <= 1'b0;
      mem_rdata_o <= 16'h0000;
      mem_hit_o <= 1'b0;
      mem_wait_o <= 1'b0;
      pm_rdata_o <= 32'h00000000;
      pm_wait_o <= 1'b0;
      lo_hold_q <= 16'h0000;
    end else begin
      mem_hit_o <= mem_sel && (mem_wr_i || mem_rd_i);
      mem_wait_o <= host_req && !host_gnt;
      pm_wait_o <= proc_req && !proc_gnt;
      if (host_req && proc_req) begin
        host_pri_q <= !host_gnt;
      end
      mem_rdata_o <= 16'h0000;
      if (host_gnt) begin
        // Low half is held, high half writes the full word.
        if (mem_wr_i && !h_high) begin
          lo_hold_q <= mem_wdata_i;
        end else if (mem_wr_i) begin
          mem[h_word] <= {mem_wdata_i, lo_hold_q};
        end
        if (mem_rd_i) begin
          mem_rdata_o <= h_high ? mem[h_word][31:16] : mem[h_word][15:0];
        end
      end else if (proc_gnt) begin
        if (pm_wr_i) begin
          mem[pm_addr_i] <= pm_wdata_i;
        end
        if (pm_rd_i) begin
          pm_rdata_o <= mem[pm_addr_i];
        end
      end
    end
  end

  // Processor timer register writes.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      conv_iv_q <= 16'h0000;
      scan_iv_q <= 16'h0000;
      count_q <= 16'h0000;
      cfg_q <= 4'h0;
    end else if (p_wr_i) begin
      case (p_addr_i)
        `ACQB_T_CONV: conv_iv_q <= p_wdata_i[15:0];
        `ACQB_T_SCAN: scan_iv_q <= p_wdata_i[15:0];
        `ACQB_T_COUNT: count_q <= p_wdata_i[15:0];
        `ACQB_T_CFG: cfg_q <= p_wdata_i[3:0];
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // Processor register reads; reading status clears the overflow flag.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      p_rdata_o <= 32'h00000000;
    end else if (p_rd_i) begin
      case (p_addr_i)
        `ACQB_T_CONV: p_rdata_o <= {16'h0000, conv_iv_q};
        `ACQB_T_SCAN: p_rdata_o <= {16'h0000, scan_iv_q};
        `ACQB_T_COUNT: p_rdata_o <= {16'h0000, done_q};
        `ACQB_T_CFG: p_rdata_o <= {28'h0000000, cfg_q};
        `ACQB_T_STATUS: p_rdata_o <= {22'h000000, fifo_full, ovf_q, 3'h0, fifo_lvl};
        default: p_rdata_o <= 32'h00000000;
      endcase
    end else begin
      p_rdata_o <= 32'h00000000;
    end
  end

  // External timebase passes three flops; the level changes once stages two and three agree.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      tb_sync_q <= 3'h0;
      tb_level_q <= 1'b0;
    end else begin
      tb_sync_q <= {tb_sync_q[1:0], ext_tb_i};
      tb_level_q <= tb_ext_lvl;
    end
  end

  // Conversion and scan pacing with sample count and sample-hold sequencing.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      conv_cnt_q <= 16'h0000;
      scan_cnt_q <= 16'h0000;
      done_q <= 16'h0000;
      chan_q <= 2'h0;
      in_scan_q <= 1'b0;
      adc_start_o <= 1'b0;
      sh_hold_o <= 1'b0;
      adc_chan_o <= 2'h0;
    end else begin
      adc_start_o <= 1'b0;
      if (!cfg_q[`ACQB_CFG_RUN] || p_reset_o) begin
        in_scan_q <= 1'b0;
        done_q <= 16'h0000;
        sh_hold_o <= 1'b0;
        conv_cnt_q <= 16'h0000;
        scan_cnt_q <= 16'h0000;
      end else if (!in_scan_q) begin
        // Wait out the scan interval, then start a scan unless the count is met.
        if (tb_tick) begin
          scan_cnt_q <= scan_cnt_q + 16'h0001;
        end
        if (scan_cnt_q >= scan_iv_q && (count_q == 16'h0000 || done_q < count_q)) begin
          in_scan_q <= 1'b1;
          scan_cnt_q <= 16'h0000;
          conv_cnt_q <= conv_lim;
          chan_q <= 2'h0;
          sh_hold_o <= cfg_q[`ACQB_CFG_SSH];
        end else if (count_q != 16'h0000 && done_q >= count_q && cfg_q[`ACQB_CFG_REPEAT]) begin
          done_q <= 16'h0000;
        end
      end else begin
        // Space conversions by the conversion interval, at least the 4 MHz period.
        if (conv_cnt_q < conv_lim) begin
          conv_cnt_q <= conv_cnt_q + {15'h0000, tb_tick};
        end else begin
          conv_cnt_q <= 16'h0000;
          adc_start_o <= 1'b1;
          adc_chan_o <= chan_q;
          chan_q <= chan_q + 2'h1;
          done_q <= done_q + 16'h0001;
          if (chan_q == 2'h3) begin
            in_scan_q <= 1'b0;
            sh_hold_o <= 1'b0;
          end
        end
      end
    end
  end

  // FIFO write of every result, dropped and flagged while full; overflow set wins over clear.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_ptr_q <= 5'h00;
      ovf_q <= 1'b0;
    end else begin
      if (adc_valid_i && !fifo_full) begin
        fifo[wr_ptr_q[3:0]] <= {adc_tag_i, adc_ext};
        wr_ptr_q <= wr_ptr_q + 5'h01;
      end
      if (adc_valid_i && fifo_full) begin
        ovf_q <= 1'b1;
      end else if (p_rd_i && p_addr_i == `ACQB_T_STATUS) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // FIFO drain into the two-entry buffer; a stalled receiver fills it and halts the drain.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      rd_ptr_q <= 5'h00;
      ob_cnt_q <= 2'd0;
      ob_rd_q <= 1'b0;
      fifo_valid_o <= 1'b0;
      fifo_data_o <= 16'h0000;
    end else begin
      if (ob_push) begin
        ob_data_q[ob_rd_q ^ ob_cnt_q[0]] <= fifo[rd_ptr_q[3:0]];
        rd_ptr_q <= rd_ptr_q + 5'h01;
      end
      if (fifo_valid_o && fifo_ready_i) begin
        ob_rd_q <= !ob_rd_q;
        ob_cnt_q <= ob_cnt_q - 2'd1 + {1'b0, ob_push};
      end else begin
        ob_cnt_q <= ob_cnt_q + {1'b0, ob_push};
      end
      if (!fifo_valid_o || fifo_ready_i) begin
        fifo_valid_o <= (ob_cnt_q > (fifo_valid_o ? 2'd1 : 2'd0));
        fifo_data_o <= ob_data_q[fifo_valid_o ? !ob_rd_q : ob_rd_q];
      end
    end
  end

  // Processor interrupts for FIFO data and DMA completion.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      p_irq_fifo_o <= 1'b0;
      p_irq_dma_o <= 1'b0;
    end else begin
      p_irq_fifo_o <= (fifo_lvl >= 5'd8) || fifo_full;
      p_irq_dma_o <= p_dma_done_i;
    end
  end

  // Host interrupt and DMA request routed to the selected levels.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      host_irq_o <= 8'h00;
      host_drq_o <= 8'h00;
    end else begin
      host_irq_o <= {7'h00, p_buf_ready_i} << levels_q[2:0];
      host_drq_o <= {7'h00, p_dma_req_i} << levels_q[5:3];
    end
  end
endmodule // acqb_ctrl
`default_nettype wire

// ===== sim/acqb_monitor.sv
`default_nettype none
// Port checker for the board control block.
module acqb_monitor (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_rdata_o,
  input wire logic mem_wr_i,
  input wire logic mem_rd_i,
  input wire logic mem_hit_o,
  input wire logic mem_wait_o,
  input wire logic pm_wr_i,
  input wire logic pm_rd_i,
  input wire logic pm_wait_o,
  input wire logic p_dma_done_i,
  input wire logic p_irq_dma_o,
  input wire logic p_reset_o,
  input wire logic adc_start_o,
  input wire logic fifo_valid_o,
  input wire logic [15:0] fifo_data_o,
  input wire logic fifo_ready_i,
  input wire logic p_buf_ready_i,
  input wire logic [7:0] host_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] gap_q;  // Cycles since the last start.
  logic seen_q;  // A start has happened.
  // Measures the spacing between conversion starts.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      gap_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      gap_q <= adc_start_o ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
      seen_q <= seen_q | adc_start_o;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_host_req;
    mem_wr_i || mem_rd_i;
  endsequence
  sequence s_stall;
    fifo_valid_o && !fifo_ready_i;
  endsequence
  a_io_idle_zero: assert property (!io_rd_i |=> io_rdata_o == 16'h0000)
    else $error("io data not zero");
  a_hit_needs_req: assert property (mem_hit_o |-> $past(mem_wr_i || mem_rd_i))
    else $error("hit without request");
  a_wait_on_tie: assert property (mem_wait_o |-> $past(pm_wr_i || pm_rd_i))
    else $error("host held off without tie");
  a_one_loser: assert property (!(mem_wait_o && pm_wait_o))
    else $error("both sides held off");
  a_dma_irq: assert property ($rose(p_dma_done_i) |=> p_irq_dma_o)
    else $error("dma irq missing");
  a_start_pulse: assert property (adc_start_o |=> !adc_start_o)
    else $error("start not a pulse");
  a_conv_gap: assert property (adc_start_o && seen_q |-> gap_q >= 8'd24)
    else $error("starts too close");
  a_stall_hold: assert property (s_stall |=> fifo_valid_o && $stable(fifo_data_o))
    else $error("word lost in stall");
  a_buf_irq: assert property (p_buf_ready_i |=> $onehot(host_irq_o))
    else $error("host irq missing");
  a_held_reset: assert property ($rose(rstn_i) |-> p_reset_o)
    else $error("processor not held");
  c_host_req: cover property (s_host_req);
endmodule  // acqb_monitor
bind acqb_ctrl acqb_monitor acqb_monitor_inst (.*);
`default_nettype wire

// ===== sim/acqb_adc_model.sv
`default_nettype none
// Converter model: answers each start after LAT cycles.
module acqb_adc_model #(
  parameter int LAT = 3
) (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [1:0] chan_i,
  output var logic valid_o,
  output var logic [13:0] data_o,
  output var logic [1:0] tag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;  // Cycles to the result.
  logic [1:0] ch_q = 2'h0;  // Channel being converted.
  initial begin
    valid_o = 1'b0;
    data_o = 14'h0;
    tag_o = 2'h0;
  end
  // Data toggles outside the valid cycle, so stale data never matches.
  always @(posedge clk_i) begin
    valid_o <= 1'b0;
    data_o <= ~data_o;
    if (start_i) begin
      cnt_q <= LAT[3:0];
      ch_q <= chan_i;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) begin
        valid_o <= 1'b1;
        data_o <= {12'h0a5, ch_q};
        tag_o <= ch_q;
      end
    end
  end
endmodule  // acqb_adc_model
`default_nettype wire

// ===== sim/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] io_sw_i = 8'h30;
  logic [15:0] io_addr_i = 16'h0, io_wdata_i = 16'h0, io_rdata_o;
  logic io_wr_i = 1'b0, io_rd_i = 1'b0, ext_tb_i = 1'b0;
  logic [23:0] mem_addr_i = 24'h0;
  logic [15:0] mem_wdata_i = 16'h0, mem_rdata_o, fifo_data_o;
  logic mem_wr_i = 1'b0, mem_rd_i = 1'b0, mem_hit_o, mem_wait_o;
  logic [2:0] p_addr_i = 3'h0;
  logic [31:0] p_wdata_i = 32'h0, p_rdata_o, pm_wdata_i = 32'h0, pm_rdata_o, r;
  logic p_wr_i = 1'b0, p_rd_i = 1'b0, pm_wr_i = 1'b0, pm_rd_i = 1'b0, pm_wait_o;
  logic [16:0] pm_addr_i = 17'h0;
  logic p_dma_done_i = 1'b0, p_buf_ready_i = 1'b0, p_dma_req_i = 1'b0;
  logic p_irq_fifo_o, p_irq_dma_o, p_reset_o, adc_start_o, sh_hold_o;
  logic [1:0] adc_chan_o, adc_tag_i;
  logic adc_valid_i, fifo_valid_o, fifo_ready_i = 1'b0;
  logic [13:0] adc_data_i;
  logic [7:0] host_irq_o, host_drq_o;
  int err_count = 0;
  int checks = 0;
  acqb_ctrl acqb_ctrl_inst (.*);
  acqb_adc_model acqb_adc_model_inst (.clk_i, .start_i(adc_start_o), .chan_i(adc_chan_o),
    .valid_o(adc_valid_i), .data_o(adc_data_i), .tag_o(adc_tag_i));
  always #5 clk_i = ~clk_i;
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Host I/O cycle; read data lands in r.
  task automatic io_acc(logic wr, logic [15:0] a, logic [15:0] d);
    @(posedge clk_i);
    io_addr_i <= a;
    io_wdata_i <= d;
    io_wr_i <= wr;
    io_rd_i <= !wr;
    @(posedge clk_i);
    io_wr_i <= 1'b0;
    io_rd_i <= 1'b0;
    #1 r = {16'h0, io_rdata_o};
  endtask
  // Processor timer register cycle.
  task automatic p_acc(logic wr, logic [2:0] a, logic [31:0] d);
    @(posedge clk_i);
    p_addr_i <= a;
    p_wdata_i <= d;
    p_wr_i <= wr;
    p_rd_i <= !wr;
    @(posedge clk_i);
    p_wr_i <= 1'b0;
    p_rd_i <= 1'b0;
    #1 r = p_rdata_o;
  endtask
  // Host memory cycle, optionally tied with a processor read.
  task automatic mem(logic wr, logic [23:0] a, logic [15:0] d, logic tie);
    @(posedge clk_i);
    mem_addr_i <= a;
    mem_wdata_i <= d;
    mem_wr_i <= wr;
    mem_rd_i <= !wr;
    pm_addr_i <= 17'h4;
    pm_rd_i <= tie;
    @(posedge clk_i);
    mem_wr_i <= 1'b0;
    mem_rd_i <= 1'b0;
    pm_rd_i <= 1'b0;
    #1 r = {16'h0, mem_rdata_o};
  endtask
  task automatic t_reset();
    io_acc(1'b0, 16'h3000, 16'h0);
    check("ctrl", r, 32'h2);
    check("held", p_reset_o, 1);
    mem(1'b0, 24'h100000, 16'h0, 1'b0);
    check("hit off", mem_hit_o, 0);
    io_acc(1'b0, 16'h3008, 16'h0);
    check("outside", r, 0);
  endtask
  task automatic t_window();
    io_acc(1'b1, 16'h3001, 16'h2);
    io_acc(1'b1, 16'h3000, 16'h1);
    @(posedge clk_i);
    #1 check("run", p_reset_o, 0);
    mem(1'b1, 24'h100010, 16'h1234, 1'b0);
    mem(1'b1, 24'h100012, 16'h5678, 1'b0);
    mem(1'b0, 24'h100012, 16'h0, 1'b0);
    check("hi", r, 32'h5678);
    mem(1'b0, 24'h17fffc, 16'h0, 1'b0);
    check("top", mem_hit_o, 1);
    mem(1'b0, 24'h180000, 16'h0, 1'b0);
    check("past", mem_hit_o, 0);
    io_acc(1'b1, 16'h3001, 16'h1f);
    mem(1'b0, 24'hf80010, 16'h0, 1'b0);
    check("moved", r, 32'h1234);
  endtask
  task automatic t_levels();
    io_acc(1'b1, 16'h3002, 16'h2b);
    p_buf_ready_i <= 1'b1;
    p_dma_req_i <= 1'b1;
    p_dma_done_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    #1 check("irq", host_irq_o, 8'h08);
    check("drq", host_drq_o, 8'h20);
    check("dma irq", p_irq_dma_o, 1);
    p_buf_ready_i <= 1'b0;
    p_dma_req_i <= 1'b0;
    p_dma_done_i <= 1'b0;
  endtask
  task automatic t_arb();
    mem(1'b0, 24'hf80010, 16'h0, 1'b1);
    check("host lost", {mem_wait_o, pm_wait_o}, 2'b10);
    check("word", pm_rdata_o, 32'h56781234);
    mem(1'b0, 24'hf80010, 16'h0, 1'b1);
    check("cpu lost", {mem_wait_o, pm_wait_o}, 2'b01);
  endtask
  task automatic t_acq();
    int n;
    p_acc(1'b1, 3'h0, 32'd25);
    p_acc(1'b1, 3'h1, 32'd200);
    p_acc(1'b1, 3'h2, 32'd4);
    p_acc(1'b1, 3'h3, 32'h5);
    n = 0;
    while (!adc_start_o && n < 500) begin
      @(posedge clk_i);
      #1 n++;
    end
    repeat (2) @(posedge clk_i);
    #1 check("hold", sh_hold_o, 1);
    repeat (300) @(posedge clk_i);
    fifo_ready_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (!(fifo_valid_o && fifo_ready_i) && n < 50);
      check("sample", fifo_data_o, {i[1:0], 12'h0a5, i[1:0]});
      @(posedge clk_i);
    end
    repeat (10) @(posedge clk_i);
    #1 check("stopped", fifo_valid_o, 0);
    p_acc(1'b0, 3'h2, 32'h0);
    check("count", r, 32'd4);
  endtask
  task automatic t_ovf();
    int n;
    fifo_ready_i <= 1'b0;
    p_acc(1'b1, 3'h2, 32'h0);
    p_acc(1'b1, 3'h3, 32'h1);
    repeat (1500) @(posedge clk_i);
    #1 check("fifo irq", p_irq_fifo_o, 1);
    io_acc(1'b0, 16'h3003, 16'h0);
    check("ovf", r[4], 1);
    p_acc(1'b1, 3'h3, 32'h0);
    fifo_ready_i <= 1'b1;
    n = 0;
    repeat (60) begin
      @(posedge clk_i);
      n += fifo_valid_o;
    end
    check("drained", n >= 16 && n <= 18, 1);
  endtask
  // External timebase: no pin edges means no samples; edges let the count finish.
  task automatic t_ext();
    p_acc(1'b1, 3'h1, 32'd2);
    p_acc(1'b1, 3'h2, 32'd4);
    p_acc(1'b1, 3'h3, 32'h3);
    repeat (100) @(posedge clk_i);
    p_acc(1'b0, 3'h2, 32'h0);
    check("no edges", r, 32'd0);
    repeat (400) begin
      repeat (2) @(posedge clk_i);
      ext_tb_i <= ~ext_tb_i;
    end
    p_acc(1'b0, 3'h2, 32'h0);
    check("ext count", r, 32'd4);
  endtask
  initial begin
    #100us;
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_window();
    t_levels();
    t_arb();
    t_acq();
    t_ovf();
    t_ext();
    end_of_test();
  end
endmodule  // tb_top
`default_nettype wire
